// File: pkg/bmdc_map.vh
// register map, field positions, reset values and timing counts of the mode/dvm block
`ifndef BMDC_MAP_VH
`define BMDC_MAP_VH

// register addresses on the serial register port
`define BMDC_ADDR_MODE 8'h04
`define BMDC_ADDR_DVM 8'h05
`define BMDC_ADDR_CORE 8'h06
`define BMDC_ADDR_RAMP 8'h07

// reset values
`define BMDC_RST_MODE 8'hb0
`define BMDC_RST_DVM 8'h40
`define BMDC_RST_CORE 8'h14
`define BMDC_RST_RAMP 8'h06

// writable bit masks, reserved bits read zero
`define BMDC_WMASK_MODE 8'hff
`define BMDC_WMASK_DVM 8'hc7
`define BMDC_WMASK_CORE 8'h1f
`define BMDC_WMASK_RAMP 8'h07

// converter_mode_phase fields
`define BMDC_PH2_HI 7
`define BMDC_PH2_LO 6
`define BMDC_PH3_HI 5
`define BMDC_PH3_LO 4
`define BMDC_LOW_RIPPLE 3
`define BMDC_FFF_TWO 2
`define BMDC_FFF_ONE 1
`define BMDC_FFF_THREE 0

// dvm_trigger_discharge fields
`define BMDC_GO 7
`define BMDC_PIN_SEL 6
`define BMDC_DIS_TWO 2
`define BMDC_DIS_ONE 1
`define BMDC_DIS_THREE 0

// core_voltage_code fields; bits 3 and 1 of the default copy the select pin
`define BMDC_CORE_HI 4
`define BMDC_CORE_PIN_B3 3
`define BMDC_CORE_PIN_B1 1

// ramp code field and its immediate code
`define BMDC_RAMP_HI 2
`define BMDC_RAMP_IMMEDIATE 3'h7

// one code step is 25 mV; slowest rate 0.15 mV/us gives 166666 ns per step
`define BMDC_STEP_MV 25
`define BMDC_STEP_NS_SLOWEST 166666
`define BMDC_CLK_MHZ 250
// 41666 cycles, sized to the 16-bit step timer so no parameter is cut silently
`define BMDC_STEP_CYC_SLOWEST 16'ha2c2

`endif

// File: rtl/bmdc_step_timer.v
// step interval timer for the core rail voltage ramp
`timescale 1ns/1ps
`default_nettype none

module bmdc_step_timer #(
  parameter [15:0] SLOWEST_CYC = 16'd41666 // cycles per step at ramp code 000
) (
  input wire ref_clk, // system clock
  input wire reset_n, // async reset, active low
  input wire run, // ramp in progress
  input wire [2:0] ramp_code, // rate code, each step up halves the interval
  output reg step_tick_ff // one-cycle pulse per code step
);

  reg [15:0] cnt_ff;
  reg [15:0] nxt_cnt;
  reg nxt_tick;
  wire [15:0] interval;

  // rate doubles per code, so the interval is a plain shift
  assign interval = SLOWEST_CYC >> ramp_code;

  always @* begin
    nxt_cnt = 16'h0000;
    nxt_tick = 1'b0;
    if (run) begin
      if (cnt_ff + 16'h0001 >= interval) begin
        nxt_tick = 1'b1;
      end else begin
        nxt_cnt = cnt_ff + 16'h0001;
      end
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt_ff <= 16'h0000;
      step_tick_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      step_tick_ff <= nxt_tick;
    end
  end

endmodule // bmdc_step_timer

`default_nettype wire

// File: rtl/bmdc_ctrl.v
// mode, phase, discharge and core voltage transition control registers
`timescale 1ns/1ps
`default_nettype none
`include "bmdc_map.vh"

module bmdc_ctrl #(
  parameter [15:0] SLOWEST_STEP_CYC = `BMDC_STEP_CYC_SLOWEST // cycles per step, slowest rate
) (
  input wire ref_clk, // system clock, 250 MHz
  input wire reset_n, // async reset, active low
  input wire reg_wr_stb, // one-cycle write strobe from the serial interface
  input wire [7:0] reg_addr, // register address for reads and writes
  input wire [7:0] reg_wdata, // write data
  output reg [7:0] reg_rdata_ff, // read data for reg_addr, one cycle later
  input wire undervoltage_lockout, // supply below lockout level, active high
  input wire buck_one_en, // buck one enabled
  input wire buck_two_en, // buck two enabled
  input wire buck_three_en, // buck three enabled
  input wire warm_reset_pin_n, // warm reset pin, active low
  input wire power_on_reset_output, // power-on reset active, active high
  input wire clock_backup_supply_low, // clock backup supply below threshold
  input wire core_default_select_pin, // core default select strap, high = 1.55 V
  output reg [1:0] buck_one_phase_ff, // phase delay code of buck one, always zero
  output reg [1:0] buck_two_phase_ff, // phase delay code of buck two
  output reg [1:0] buck_three_phase_ff, // phase delay code of buck three
  output reg low_ripple_ff, // light-load mode tuned for low ripple
  output reg [2:0] forced_fixed_freq_ff, // forced pwm, bit0 one, bit1 two, bit2 three
  output reg [2:0] discharge_active_ff, // discharge on, bit0 one, bit1 two, bit2 three
  output reg core_pin_select_ff, // core voltage taken from the select pin
  output reg [4:0] core_rail_output_code_ff, // stepped core voltage code
  output reg dynamic_voltage_transition_ff // transition in progress
);

  // ------------------------------------------------------------------
  // constants
  // ------------------------------------------------------------------
  // the stepped code leaves reset at the unstrapped default; the strap
  // only takes effect through a reload event
  localparam [7:0] RST_CORE = `BMDC_RST_CORE;
  localparam [4:0] RST_CODE = RST_CORE[`BMDC_CORE_HI:0];

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  // write only the writable bits, reserved ones stay zero
  function [7:0] masked_write;
    input [7:0] wdata;
    input [7:0] mask;
    begin
      masked_write = wdata & mask;
    end
  endfunction

  // default of the core code with the strap copied in
  function [7:0] core_default;
    input pin;
    begin
      core_default = `BMDC_RST_CORE;
      core_default[`BMDC_CORE_PIN_B3] = pin;
      core_default[`BMDC_CORE_PIN_B1] = pin;
    end
  endfunction

  // one-hot select of the mapped registers, zero when unmapped; shared by
  // the write strobes and the read mux so the two can never disagree
  function [3:0] reg_select;
    input [7:0] addr;
    begin
      if (addr == `BMDC_ADDR_MODE) begin
        reg_select = 4'h1;
      end else if (addr == `BMDC_ADDR_DVM) begin
        reg_select = 4'h2;
      end else if (addr == `BMDC_ADDR_CORE) begin
        reg_select = 4'h4;
      end else if (addr == `BMDC_ADDR_RAMP) begin
        reg_select = 4'h8;
      end else begin
        reg_select = 4'h0;
      end
    end
  endfunction

  // ------------------------------------------------------------------
  // registers
  // ------------------------------------------------------------------
  // reserved bits are masked on every write, so the stored copies
  // read back zero without a separate read mask
  reg [7:0] mode_ff;
  reg [7:0] dvm_ff;
  reg [7:0] core_ff;
  reg [7:0] ramp_ff;
  reg [7:0] nxt_mode;
  reg [7:0] nxt_dvm;
  reg [7:0] nxt_core;
  reg [7:0] nxt_ramp;
  reg [4:0] nxt_step_code;

  wire wr_mode;
  wire wr_dvm;
  wire wr_core;
  wire wr_ramp;
  wire core_reload;
  wire go;
  wire immediate;
  wire at_target;
  wire step_tick;
  wire [4:0] target_code;

  wire [3:0] reg_hit;
  assign reg_hit = reg_select(reg_addr);
  assign wr_mode = reg_wr_stb && reg_hit[0];
  assign wr_dvm = reg_wr_stb && reg_hit[1];
  assign wr_core = reg_wr_stb && reg_hit[2];
  assign wr_ramp = reg_wr_stb && reg_hit[3];

  // any of the five events reloads the core code default
  assign core_reload = undervoltage_lockout || (!buck_one_en && !buck_three_en) ||
                       !warm_reset_pin_n || power_on_reset_output ||
                       clock_backup_supply_low;

  // strap-dependent default, shared by every reload path
  wire [7:0] core_dflt;
  assign core_dflt = core_default(core_default_select_pin);

  assign go = dvm_ff[`BMDC_GO];
  assign target_code = core_ff[`BMDC_CORE_HI:0];
  assign immediate = (ramp_ff[`BMDC_RAMP_HI:0] == `BMDC_RAMP_IMMEDIATE);
  assign at_target = (core_rail_output_code_ff == target_code);

  // ------------------------------------------------------------------
  // ramp timing
  // ------------------------------------------------------------------
  // timer restarts whenever the ramp pauses, so a new transition always
  // waits a full interval before its first step
  // limitation: below 64 the fastest codes shift the interval to zero and
  // then all of them step every cycle
  bmdc_step_timer #(
    .SLOWEST_CYC(SLOWEST_STEP_CYC)
  ) u_step_timer (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .run(go && !at_target && !immediate && !undervoltage_lockout),
    .ramp_code(ramp_ff[`BMDC_RAMP_HI:0]),
    .step_tick_ff(step_tick)
  );

  // ------------------------------------------------------------------
  // next-state of the register file
  // ------------------------------------------------------------------
  // later assignments win: ramp self-clear, then host writes, then reload
  // events, and lockout last since it must override everything
  always @* begin
    nxt_mode = mode_ff;
    nxt_dvm = dvm_ff;
    nxt_core = core_ff;
    nxt_ramp = ramp_ff;
    nxt_step_code = core_rail_output_code_ff;

    // trigger done: the code reached the target, not the rail settled
    if (go && at_target) begin
      nxt_dvm[`BMDC_GO] = 1'b0;
    end
    if (go && !at_target) begin
      if (immediate) begin
        nxt_step_code = target_code;
        nxt_dvm[`BMDC_GO] = 1'b0;
      end else if (step_tick) begin
        if (core_rail_output_code_ff < target_code) begin
          nxt_step_code = core_rail_output_code_ff + 5'h01;
        end else begin
          nxt_step_code = core_rail_output_code_ff - 5'h01;
        end
      end
    end

    // host writes land after the self-clear, so a new trigger is not lost
    if (wr_mode) begin
      nxt_mode = masked_write(reg_wdata, `BMDC_WMASK_MODE);
    end
    if (wr_dvm) begin
      nxt_dvm = masked_write(reg_wdata, `BMDC_WMASK_DVM);
    end
    if (wr_core) begin
      nxt_core = masked_write(reg_wdata, `BMDC_WMASK_CORE);
    end
    if (wr_ramp) begin
      nxt_ramp = masked_write(reg_wdata, `BMDC_WMASK_RAMP);
    end

    if (core_reload) begin
      nxt_core = core_dflt;
      if (!go) begin
        nxt_step_code = core_dflt[`BMDC_CORE_HI:0];
      end
    end
    if (undervoltage_lockout) begin
      nxt_mode = `BMDC_RST_MODE;
      nxt_dvm = `BMDC_RST_DVM;
      nxt_ramp = `BMDC_RST_RAMP;
      nxt_step_code = core_dflt[`BMDC_CORE_HI:0];
    end
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      mode_ff <= `BMDC_RST_MODE;
      dvm_ff <= `BMDC_RST_DVM;
      core_ff <= `BMDC_RST_CORE;
      ramp_ff <= `BMDC_RST_RAMP;
      core_rail_output_code_ff <= RST_CODE;
    end else begin
      mode_ff <= nxt_mode;
      dvm_ff <= nxt_dvm;
      core_ff <= nxt_core;
      ramp_ff <= nxt_ramp;
      core_rail_output_code_ff <= nxt_step_code;
    end
  end

  // ------------------------------------------------------------------
  // converter controls
  // ------------------------------------------------------------------
  // discharge only matters while a converter is off; the enable is sampled
  // here, so a converter that turns off starts discharging one cycle later
  wire [2:0] conv_en;
  wire [2:0] dis_bits;
  assign conv_en = {buck_three_en, buck_two_en, buck_one_en};
  assign dis_bits = {dvm_ff[`BMDC_DIS_THREE], dvm_ff[`BMDC_DIS_TWO], dvm_ff[`BMDC_DIS_ONE]};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1) begin : g_discharge
      always @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
          discharge_active_ff[gi] <= 1'b0;
        end else begin
          discharge_active_ff[gi] <= dis_bits[gi] && !conv_en[gi];
        end
      end
    end
  endgenerate

  // every port comes straight from a flop, at the cost of one cycle
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      buck_one_phase_ff <= 2'h0;
      buck_two_phase_ff <= 2'h0;
      buck_three_phase_ff <= 2'h0;
      low_ripple_ff <= 1'b0;
      forced_fixed_freq_ff <= 3'h0;
      core_pin_select_ff <= 1'b0;
      dynamic_voltage_transition_ff <= 1'b0;
    end else begin
      buck_one_phase_ff <= 2'h0;
      buck_two_phase_ff <= mode_ff[`BMDC_PH2_HI:`BMDC_PH2_LO];
      buck_three_phase_ff <= mode_ff[`BMDC_PH3_HI:`BMDC_PH3_LO];
      low_ripple_ff <= mode_ff[`BMDC_LOW_RIPPLE];
      forced_fixed_freq_ff <= {mode_ff[`BMDC_FFF_THREE], mode_ff[`BMDC_FFF_TWO],
                               mode_ff[`BMDC_FFF_ONE]};
      core_pin_select_ff <= dvm_ff[`BMDC_PIN_SEL];
      dynamic_voltage_transition_ff <= go;
    end
  end

  // ------------------------------------------------------------------
  // read side
  // ------------------------------------------------------------------
  // reads need no strobe; data trails the address by one edge
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_hit[0]) begin
      reg_rdata_ff <= mode_ff;
    end else if (reg_hit[1]) begin
      reg_rdata_ff <= dvm_ff;
    end else if (reg_hit[2]) begin
      reg_rdata_ff <= core_ff;
    end else if (reg_hit[3]) begin
      reg_rdata_ff <= ramp_ff;
    end else begin
      reg_rdata_ff <= 8'h00;
    end
  end

endmodule // bmdc_ctrl

`default_nettype wire

// File: sim/bmdc_host_model.sv
// host model: register writes and read address selection
`timescale 1ns/1ps
`default_nettype none
module bmdc_host_model (
  input wire logic ref_clk, // clock
  output logic reg_wr_stb, // write strobe
  output logic [7:0] reg_addr, // address
  output logic [7:0] reg_wdata // write data
);
  initial begin
    reg_wr_stb = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // one-edge strobe; an idle edge always follows, so calls never collide
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk) #1;
    reg_wr_stb = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge ref_clk) #1;
    reg_wr_stb = 1'b0;
    reg_wdata = ~d; // stale data never looks valid
  endtask
  task automatic sel(input logic [7:0] a);
    @(posedge ref_clk) #1;
    reg_addr = a;
  endtask
endmodule // bmdc_host_model
`default_nettype wire

// File: sim/bmdc_ctrl_monitor.sv
// port assertions of the mode and core transition control block
`timescale 1ns/1ps
`default_nettype none
module bmdc_ctrl_monitor (
  input wire ref_clk, // clock
  input wire reset_n, // reset, low
  input wire reg_wr_stb, // strobe
  input wire [7:0] reg_addr, // address
  input wire [7:0] reg_wdata, // data
  input wire [7:0] reg_rdata_ff, // read data
  input wire undervoltage_lockout, // lockout
  input wire buck_one_en, // enable
  input wire buck_two_en, // enable
  input wire buck_three_en, // enable
  input wire core_default_select_pin, // strap
  input wire [1:0] buck_one_phase_ff, // phase
  input wire [1:0] buck_two_phase_ff, // phase
  input wire [1:0] buck_three_phase_ff, // phase
  input wire low_ripple_ff, // ripple mode
  input wire [2:0] forced_fixed_freq_ff, // pwm
  input wire [2:0] discharge_active_ff, // discharge
  input wire core_pin_select_ff, // pin select
  input wire [4:0] core_rail_output_code_ff, // code
  input wire dynamic_voltage_transition_ff // ramp on
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire mode_wr = reg_wr_stb && reg_addr == 8'h04 && !undervoltage_lockout;
  wire go_wr = reg_wr_stb && reg_addr == 8'h05 && reg_wdata[7] && !undervoltage_lockout;
  wire p = core_default_select_pin;
  phase_ref_a: assert property (buck_one_phase_ff == 2'h0)
    else $error("buck one phase not zero");
  phase_map_a: assert property (mode_wr |-> ##2
    {buck_two_phase_ff, buck_three_phase_ff} == $past(reg_wdata[7:4], 2))
    else $error("phase codes do not follow mode write");
  mode_bits_a: assert property (mode_wr |-> ##2 low_ripple_ff == $past(reg_wdata[3], 2)
    && forced_fixed_freq_ff == {$past(reg_wdata[0], 2), $past(reg_wdata[2], 2), $past(reg_wdata[1], 2)})
    else $error("ripple or pwm bits wrong");
  reserved_zero_a: assert property (($past(reg_addr) != 8'h06 || reg_rdata_ff[7:5] == 3'h0)
    && ($past(reg_addr) != 8'h07 || reg_rdata_ff[7:3] == 5'h00))
    else $error("reserved code bits read nonzero");
  discharge_gate_a: assert property ((discharge_active_ff &
    {$past(buck_three_en), $past(buck_two_en), $past(buck_one_en)}) == 3'h0)
    else $error("discharge while converter enabled");
  lockout_load_a: assert property (undervoltage_lockout |-> ##2 core_pin_select_ff
    && {buck_two_phase_ff, buck_three_phase_ff} == 4'hb && !low_ripple_ff
    && forced_fixed_freq_ff == 3'h0 && discharge_active_ff == 3'h0)
    else $error("lockout defaults not applied");
  trigger_clear_a: assert property (undervoltage_lockout [*2] |=> !dynamic_voltage_transition_ff)
    else $error("lockout left transition running");
  core_reload_a: assert property (undervoltage_lockout [*3] |->
    core_rail_output_code_ff == {1'b1, $past(p), 1'b1, $past(p), 1'b0})
    else $error("core code not at strap default");
  go_start_a: assert property (go_wr |-> ##2 dynamic_voltage_transition_ff)
    else $error("trigger write did not start transition");
  cover property (undervoltage_lockout [*3]);
  cover property ($fell(dynamic_voltage_transition_ff));
  cover property (discharge_active_ff != 3'h0);
endmodule // bmdc_ctrl_monitor
bind bmdc_ctrl bmdc_ctrl_monitor bmdc_ctrl_monitor_inst (.ref_clk, .reset_n, .reg_wr_stb,
  .reg_addr, .reg_wdata, .reg_rdata_ff, .undervoltage_lockout, .buck_one_en, .buck_two_en,
  .buck_three_en, .core_default_select_pin, .buck_one_phase_ff, .buck_two_phase_ff,
  .buck_three_phase_ff, .low_ripple_ff, .forced_fixed_freq_ff, .discharge_active_ff,
  .core_pin_select_ff, .core_rail_output_code_ff, .dynamic_voltage_transition_ff);
`default_nettype wire

// File: sim/test_bmdc_ctrl.sv
// self-checking bench of the mode, phase and core transition control
`timescale 1ns/1ps
`default_nettype none
module test_bmdc_ctrl;
  localparam int STEP = 64; // short slowest interval keeps ramps brief
  logic ref_clk = 0, reset_n = 0, lockout = 0, warm_rst_n = 1, por = 0, vbk = 0, sel_pin = 0;
  logic [2:0] en = 3'h7;
  wire stb, ripple, psel, dynamic_voltage_transition;
  wire [7:0] addr, wdata, rdata;
  wire [1:0] ph1, ph2, ph3;
  wire [2:0] fff, dis;
  wire [4:0] code;
  int bad_count = 0, compares = 0, n, k, d;
  logic [7:0] v;
  logic [4:0] t, s;
  bmdc_host_model bmdc_host_model_inst (.ref_clk(ref_clk), .reg_wr_stb(stb), .reg_addr(addr),
    .reg_wdata(wdata));
  bmdc_ctrl #(.SLOWEST_STEP_CYC(16'd64)) bmdc_ctrl_inst (.ref_clk(ref_clk), .reset_n(reset_n),
    .reg_wr_stb(stb), .reg_addr(addr), .reg_wdata(wdata), .reg_rdata_ff(rdata),
    .undervoltage_lockout(lockout), .buck_one_en(en[0]), .buck_two_en(en[1]),
    .buck_three_en(en[2]), .warm_reset_pin_n(warm_rst_n), .power_on_reset_output(por),
    .clock_backup_supply_low(vbk), .core_default_select_pin(sel_pin),
    .buck_one_phase_ff(ph1), .buck_two_phase_ff(ph2), .buck_three_phase_ff(ph3),
    .low_ripple_ff(ripple), .forced_fixed_freq_ff(fff), .discharge_active_ff(dis),
    .core_pin_select_ff(psel), .core_rail_output_code_ff(code),
    .dynamic_voltage_transition_ff(dynamic_voltage_transition));
  function automatic logic [7:0] dflt(int a);
    return a == 4 ? 8'hb0 : a == 5 ? 8'h40 : a == 6 ? 8'h14 : a == 7 ? 8'h06 : 8'h00;
  endfunction
  // each rate code halves the per-step interval; code 111 jumps at once
  function automatic logic ramp_ok(int code_sel, int steps, int waited);
    if (code_sel == 7) return waited < 3;
    return waited + 3 >= steps * (STEP >> code_sel) && waited <= steps * (STEP >> code_sel) + 4;
  endfunction
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    compares++;
    if (got !== exp) begin
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e);
    bmdc_host_model_inst.sel(a);
    @(posedge ref_clk) #1;
    chk("rdata", e, rdata);
  endtask
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  initial forever #2 ref_clk = ~ref_clk;
  initial begin
    #200000;
    bad_count++;
    conclude();
  end
  initial begin
    n = $urandom(42);
    repeat (6) @(posedge ref_clk);
    #1 reset_n = 1;
    for (n = 4; n < 9; n++) rd(n[7:0], dflt(n));
    repeat (12) begin
      v = 8'($urandom);
      bmdc_host_model_inst.wr(8'h04, v);
      @(posedge ref_clk) #1;
      chk("mode", v, {ph2, ph3, ripple, fff[1], fff[0], fff[2]});
      chk("phase one", 8'h00, {6'h0, ph1});
    end
    repeat (8) begin
      v = 8'($urandom) & 8'h47;
      bmdc_host_model_inst.wr(8'h05, v);
      en = 3'($urandom);
      @(posedge ref_clk) #1;
      chk("discharge", {5'h0, v[0] & ~en[2], v[2] & ~en[1], v[1] & ~en[0]}, {5'h0, dis});
      chk("pin select", {7'h0, v[6]}, {7'h0, psel});
    end
    en = 3'h7;
    // every ramp code, 111 included, walks to a random target
    for (k = 0; k < 8; k++) begin
      v = 8'($urandom); // random reserved bits must not stick
      t = v[4:0];
      s = code;
      d = t > s ? t - s : s - t;
      bmdc_host_model_inst.wr(8'h07, {5'h1f, k[2:0]});
      bmdc_host_model_inst.wr(8'h06, v);
      bmdc_host_model_inst.wr(8'h05, 8'hc0);
      @(posedge ref_clk) #1;
      chk("transition", 8'h01, {7'h0, dynamic_voltage_transition});
      for (n = 0; n < 3000 && dynamic_voltage_transition !== 1'b0; n++) @(posedge ref_clk) #1;
      chk("core code", {3'h0, t}, {3'h0, code});
      chk("ramp time", 8'h01, {7'h0, ramp_ok(k, d, n)});
      rd(8'h05, 8'h40);
      rd(8'h06, {3'h0, t});
      rd(8'h07, {5'h00, k[2:0]});
    end
    // each reload source, lockout arriving the cycle after the trigger, before the first step
    for (n = 0; n < 5; n++) begin
      sel_pin = 1'($urandom);
      bmdc_host_model_inst.wr(8'h07, 8'h00);
      bmdc_host_model_inst.wr(8'h06, {3'h0, ~code});
      bmdc_host_model_inst.wr(8'h05, 8'h80);
      lockout = n == 0;
      warm_rst_n = n != 1;
      por = n == 2;
      vbk = n == 3;
      en = n == 4 ? 3'h2 : 3'h7;
      repeat (4) @(posedge ref_clk) #1;
      {lockout, warm_rst_n, por, vbk, en} = 7'h27;
      rd(8'h06, {3'h0, 1'b1, sel_pin, 1'b1, sel_pin, 1'b0});
      if (n == 0) for (k = 4; k < 8; k++) if (k != 6) rd(k[7:0], dflt(k));
    end
    conclude();
  end
endmodule // test_bmdc_ctrl
`default_nettype wire
